// ===== tsc_device.sv
// converter end: control byte decode, sequencing and result shift-out
// Function
// - exchanges of eight clocks, 24 per conversion
// - host sends control byte in first eight
// - acquire from bit five, hold after eight
// - drivers off during single-ended conversion
// - twelve conversion clocks, thirteenth gives last bit
// - ratiometric keeps drivers on while converting
// - trailing clocks drive output low, ignored
// - first high bit is the start marker
// - next byte every 15th or 11th clock
// - byte layout start, address, resolution, reference, power
// - address and reference mode steer mux, drivers
// - resolution bit picks 12 or 8 bits
// - reference mode high single-ended, low ratiometric
// - host uses ratiometric only for touch channels
// - code 00 auto power-down, Y-minus stays on
// - codes 01 and 10 split reference, converter
// - code 11 always on, interrupt disabled
// - reference state latched at busy rise
// - host waits for reference settling
// - address 000 unit bias, 111 82x bias
// - battery divider, temp bias only while acquiring
// - chip select high aborts, reference kept
`timescale 1ns/1ps
module tsc_device
	import tsc_pkg::*;
(
	input wire logic CLK,
	input wire logic RESETN,
	tsc_link_if.dev LINK,
	input wire logic [11:0] ADC_RESULT,
	input wire logic PEN_TOUCH,
	output logic [2:0] MUX_SEL,
	output logic DRIVERS_ON,
	output logic YMINUS_ON,
	output logic REF_DIFF,
	output logic REF_ON,
	output logic ADC_ON,
	output logic SAMPLE_HOLD,
	output logic TEMP_BIAS,
	output logic TEMP_BIAS_X82,
	output logic BAT_DIV_ON
);

	// touch-panel channels that need the panel drivers
	function automatic logic is_touch(input logic [2:0] a);
		is_touch = (a == 3'h1) || (a == 3'h3) || (a == 3'h4) || (a == 3'h5);
	endfunction : is_touch

	logic sclk_s1, sclk_s2, sclk_d;
	logic cs_s1, cs_s2;
	logic din_s1, din_s2;
	logic pen_s1, pen_s2;
	logic rise, fall, desel;
	tsc_ctl_t ctl;
	logic [7:0] shreg;
	logic [4:0] bit_cnt;
	logic [4:0] edge_cnt;
	logic [4:0] gap;
	logic [2:0] addr;
	logic res8;
	logic ref_mode;
	logic [1:0] pwr;
	logic acq;
	logic conv;
	logic load_pend;
	logic [11:0] held;
	logic [11:0] out_sh;
	logic [3:0] out_left;
	logic dout, busy, link_oe, pen_oe;

	// pins from the other chip pass two flops first
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_d <= 1'b0;
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			din_s1 <= 1'b0;
			din_s2 <= 1'b0;
			pen_s1 <= 1'b0;
			pen_s2 <= 1'b0;
		end else begin
			sclk_s1 <= LINK.serial_shift_clock;
			sclk_s2 <= sclk_s1;
			sclk_d <= sclk_s2;
			cs_s1 <= LINK.cs_n;
			cs_s2 <= cs_s1;
			din_s1 <= LINK.din;
			din_s2 <= din_s1;
			pen_s1 <= PEN_TOUCH;
			pen_s2 <= pen_s1;
		end
	end

	assign desel = cs_s2;
	assign rise = !desel && sclk_s2 && !sclk_d;
	assign fall = !desel && !sclk_s2 && sclk_d;
	assign gap = res8 ? GAP_8BIT : GAP_12BIT;

	// control byte reception on rising edges
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ctl <= TSC_WAIT;
			shreg <= 8'h00;
			bit_cnt <= 5'h00;
			edge_cnt <= EDGE_SAT;
			addr <= 3'h0;
			res8 <= 1'b0;
			ref_mode <= 1'b1;
			pwr <= PWR_AUTO;
			acq <= 1'b0;
			load_pend <= 1'b0;
			held <= 12'h000;
		end else if (desel) begin
			ctl <= TSC_WAIT;
			bit_cnt <= 5'h00;
			edge_cnt <= EDGE_SAT;
			acq <= 1'b0;
			load_pend <= 1'b0;
		end else begin
			if (fall && load_pend) begin
				load_pend <= 1'b0;
			end
			if (rise) begin
				if (edge_cnt != EDGE_SAT) begin
					edge_cnt <= edge_cnt + 5'h01;
				end
				case (ctl)
					TSC_WAIT: begin
						// start marker, no earlier than the gap
						if (din_s2 && edge_cnt >= gap) begin
							ctl <= TSC_BYTE;
							shreg <= 8'h01;
							bit_cnt <= 5'h01;
							edge_cnt <= 5'h01;
						end
					end
					TSC_BYTE: begin
						shreg <= {shreg[6:0], din_s2};
						bit_cnt <= bit_cnt + 5'h01;
						// acquisition once address and resolution known
						if (bit_cnt + 5'h01 == ACQ_START_BIT) begin
							addr <= shreg[2:0];
							res8 <= din_s2;
							acq <= 1'b1;
						end
						if (bit_cnt + 5'h01 == BYTE_CLOCKS) begin
							// last bit not shifted yet, so earlier fields sit one place low
							ref_mode <= shreg[REFMODE_BIT - 1];
							pwr <= {shreg[PWR_HI - 1], din_s2};
							acq <= 1'b0;
							load_pend <= 1'b1;
							held <= ADC_RESULT;
							ctl <= TSC_WAIT;
						end
					end
					default: begin
						ctl <= TSC_WAIT;
					end
				endcase
			end
		end
	end

	// result shift-out on falling edges
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			conv <= 1'b0;
			busy <= 1'b0;
			dout <= 1'b0;
			out_sh <= 12'h000;
			out_left <= 4'h0;
		end else if (desel) begin
			conv <= 1'b0;
			busy <= 1'b0;
			dout <= 1'b0;
			out_left <= 4'h0;
		end else if (fall) begin
			if (load_pend) begin
				busy <= 1'b1;
				dout <= 1'b0;
				conv <= 1'b1;
				out_sh <= held;
				out_left <= res8 ? LEN_8BIT : LEN_12BIT;
			end else begin
				busy <= 1'b0;
				if (out_left != 4'h0) begin
					// MSB first on falling edges, conversion bits
					dout <= out_sh[11];
					out_sh <= {out_sh[10:0], 1'b0};
					out_left <= out_left - 4'h1;
				end else begin
					dout <= 1'b0;
					conv <= 1'b0;
				end
			end
		end
	end

	// reference power taken when busy rises; kept through deselect
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			REF_ON <= 1'b0;
		end else if (!desel && fall && load_pend) begin
			REF_ON <= pwr[PWR_HI];
		end
	end

	// switch, bias and power controls
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			MUX_SEL <= 3'h0;
			DRIVERS_ON <= 1'b0;
			YMINUS_ON <= 1'b1;
			REF_DIFF <= 1'b0;
			ADC_ON <= 1'b0;
			SAMPLE_HOLD <= 1'b0;
			TEMP_BIAS <= 1'b0;
			TEMP_BIAS_X82 <= 1'b0;
			BAT_DIV_ON <= 1'b0;
		end else begin
			MUX_SEL <= addr;
			REF_DIFF <= !ref_mode;
			// drivers on while acquiring, during conversion only if ratiometric
			DRIVERS_ON <= is_touch(addr) && (acq || (conv && !ref_mode));
			// Y-minus held on while powered down in auto mode
			YMINUS_ON <= (pwr == PWR_AUTO) && !acq && !conv;
			ADC_ON <= acq || conv || pwr == PWR_REF_OFF || pwr == PWR_ALWAYS;
			SAMPLE_HOLD <= conv;
			// bias and divider only while acquiring
			TEMP_BIAS <= acq && addr == ADDR_TEMP0;
			TEMP_BIAS_X82 <= acq && addr == ADDR_TEMP1;
			BAT_DIV_ON <= acq && addr == ADDR_BATT;
		end
	end

	// pin drivers: released while deselected, touch line pulled low
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			link_oe <= 1'b0;
			pen_oe <= 1'b0;
		end else begin
			link_oe <= !desel;
			// interrupt silent in always-on mode; quiet from acquisition start until conversion ends
			pen_oe <= pwr != PWR_ALWAYS && pen_s2 && !acq && !load_pend && !conv;
		end
	end

	assign LINK.dout = dout;
	assign LINK.dout_oe = link_oe;
	assign LINK.busy = busy;
	assign LINK.busy_oe = link_oe;
	assign LINK.touch_interrupt_out_n = 1'b0;
	assign LINK.touch_interrupt_oe = pen_oe;

endmodule : tsc_device

// ===== tsc_pkg.sv
// shared constants and types for the touch converter serial link
package tsc_pkg;
	// control byte field positions
	localparam int unsigned START_BIT = 7;
	localparam int unsigned ADDR_HI = 6;
	localparam int unsigned ADDR_LO = 4;
	localparam int unsigned RES_BIT = 3;
	localparam int unsigned REFMODE_BIT = 2;
	localparam int unsigned PWR_HI = 1;
	localparam int unsigned PWR_LO = 0;
	// serial sequence counts, in serial clocks
	localparam logic [4:0] BYTE_CLOCKS = 5'h08;
	localparam logic [4:0] ACQ_START_BIT = 5'h05;
	localparam logic [4:0] FRAME_CLOCKS = 5'h18;
	localparam logic [4:0] GAP_12BIT = 5'h0F;
	localparam logic [4:0] GAP_8BIT = 5'h0B;
	localparam logic [4:0] EDGE_SAT = 5'h1F;
	localparam logic [3:0] LEN_12BIT = 4'hC;
	localparam logic [3:0] LEN_8BIT = 4'h8;
	// channel addresses with side effects
	localparam logic [2:0] ADDR_TEMP0 = 3'h0;
	localparam logic [2:0] ADDR_BATT = 3'h2;
	localparam logic [2:0] ADDR_TEMP1 = 3'h7;
	// power mode codes
	localparam logic [1:0] PWR_AUTO = 2'h0;
	localparam logic [1:0] PWR_REF_OFF = 2'h1;
	localparam logic [1:0] PWR_ALWAYS = 2'h3;
	// host timing: serial clock half period
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned SCLK_HALF_NS = 250;
	localparam logic [3:0] SCLK_HALF_CYC = 4'((SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// host register map, then first serial clock the host samples
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_RESULT = 8'h08;
	localparam logic [4:0] SAMPLE_FIRST = 5'h09;
	typedef enum logic [1:0] {
		TSC_WAIT = 2'b00,
		TSC_BYTE = 2'b01
	} tsc_ctl_t;
	typedef enum logic [1:0] {
		TSC_H_IDLE = 2'b00,
		TSC_H_SETUP = 2'b01,
		TSC_H_RUN = 2'b10,
		TSC_H_END = 2'b11
	} tsc_host_t;
endpackage : tsc_pkg

// ===== tsc_link_if.sv
// serial link between host and touch converter
`timescale 1ns/1ps
interface tsc_link_if;
	logic serial_shift_clock;
	logic cs_n;
	logic din;
	logic dout;
	logic dout_oe;
	logic busy;
	logic busy_oe;
	logic touch_interrupt_out_n;
	logic touch_interrupt_oe;
	modport dev (
		input serial_shift_clock,
		input cs_n,
		input din,
		output dout,
		output dout_oe,
		output busy,
		output busy_oe,
		output touch_interrupt_out_n,
		output touch_interrupt_oe
	);
	modport host (
		output serial_shift_clock,
		output cs_n,
		output din,
		input dout,
		input dout_oe,
		input busy,
		input busy_oe,
		input touch_interrupt_out_n,
		input touch_interrupt_oe
	);
endinterface : tsc_link_if

// ===== tsc_host.sv
// host end: APB registers driving a 24-clock conversion frame
`timescale 1ns/1ps
module tsc_host
	import tsc_pkg::*;
(
	input wire logic CLK,
	input wire logic RESETN,
	tsc_link_if.host LINK,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR
);

	logic dout_s1, dout_s2, pen_s1, pen_s2;
	tsc_host_t st;
	logic [3:0] div;
	logic [4:0] clk_cnt;
	logic sclk, cs_n, din;
	logic [7:0] ctrl_byte;
	logic [15:0] rx;
	logic [11:0] result;
	logic done;
	logic start_req;
	logic wr_ctrl;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			dout_s1 <= 1'b0;
			dout_s2 <= 1'b0;
			pen_s1 <= 1'b0;
			pen_s2 <= 1'b0;
		end else begin
			dout_s1 <= LINK.dout_oe ? LINK.dout : 1'b0;
			dout_s2 <= dout_s1;
			pen_s1 <= LINK.touch_interrupt_oe;
			pen_s2 <= pen_s1;
		end
	end

	assign wr_ctrl = PSEL && PENABLE && PWRITE && !PREADY && PADDR == REG_CTRL;

	// APB slave, one wait state; control writes during a frame are dropped
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h0000_0000;
			ctrl_byte <= 8'h00;
			start_req <= 1'b0;
		end else begin
			PREADY <= PSEL && PENABLE && !PREADY;
			PSLVERR <= 1'b0;
			start_req <= 1'b0;
			if (PSEL && PENABLE && !PREADY) begin
				if (PADDR == REG_CTRL) begin
					PRDATA <= {24'h000000, ctrl_byte};
				end else if (PADDR == REG_STATUS) begin
					PRDATA <= {29'h00000000, pen_s2, done, st != TSC_H_IDLE};
				end else if (PADDR == REG_RESULT) begin
					PRDATA <= {20'h00000, result};
				end else begin
					PRDATA <= 32'h0000_0000;
					PSLVERR <= 1'b1;
				end
			end
			if (wr_ctrl && st == TSC_H_IDLE) begin
				// start marker forced in the byte
				ctrl_byte <= PWDATA[7:0] | 8'h80;
				start_req <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			st <= TSC_H_IDLE;
			div <= 4'h0;
			clk_cnt <= 5'h00;
			sclk <= 1'b0;
			cs_n <= 1'b1;
			din <= 1'b0;
			rx <= 16'h0000;
			result <= 12'h000;
			done <= 1'b0;
		end else begin
			case (st)
				TSC_H_IDLE: begin
					if (start_req) begin
						st <= TSC_H_SETUP;
						cs_n <= 1'b0;
						done <= 1'b0;
						div <= 4'h0;
						clk_cnt <= 5'h00;
						// first control bit ahead of the first edge
						din <= 1'b1;
					end
				end
				TSC_H_SETUP: begin
					div <= div + 4'h1;
					if (div == SCLK_HALF_CYC - 4'h1) begin
						st <= TSC_H_RUN;
						div <= 4'h0;
					end
				end
				TSC_H_RUN: begin
					div <= div + 4'h1;
					if (div == SCLK_HALF_CYC - 4'h1) begin
						div <= 4'h0;
						sclk <= !sclk;
						if (!sclk) begin
							clk_cnt <= clk_cnt + 5'h01;
						end else begin
							// sample late in the high phase, then move data
							if (clk_cnt >= SAMPLE_FIRST) begin
								rx <= {rx[14:0], dout_s2};
							end
							din <= clk_cnt < BYTE_CLOCKS ? ctrl_byte[3'(BYTE_CLOCKS - clk_cnt - 5'h01)] : 1'b0;
							if (clk_cnt == FRAME_CLOCKS) begin
								st <= TSC_H_END;
							end
						end
					end
				end
				TSC_H_END: begin
					cs_n <= 1'b1;
					done <= 1'b1;
					// 8-bit result sits in the upper bits
					result <= ctrl_byte[RES_BIT] ? {4'h0, rx[14:7]} : rx[14:3];
					st <= TSC_H_IDLE;
				end
				default: begin
					st <= TSC_H_IDLE;
				end
			endcase
		end
	end

	assign LINK.serial_shift_clock = sclk;
	assign LINK.cs_n = cs_n;
	assign LINK.din = din;

endmodule : tsc_host

// ===== tsc_link_monitor.sv
// concurrent checks on the host-converter serial link
`timescale 1ns/1ps
module tsc_link_monitor
	import tsc_pkg::*;
(
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic serial_shift_clock,
	input wire logic cs_n,
	input wire logic din,
	input wire logic dout,
	input wire logic dout_oe,
	input wire logic busy,
	input wire logic busy_oe,
	input wire logic touch_interrupt_out_n,
	input wire logic touch_interrupt_oe
);
	logic sclk_q;
	logic [4:0] edge_cnt;
	logic [7:0] ctl;
	logic rise;
	assign rise = serial_shift_clock && !sclk_q;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= serial_shift_clock;
		end
	end
	// count rises inside a frame, cleared while deselected
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			edge_cnt <= 5'h00;
		end else if (cs_n) begin
			edge_cnt <= 5'h00;
		end else if (rise) begin
			edge_cnt <= edge_cnt + 5'h01;
		end
	end
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ctl <= 8'h00;
		end else if (rise && !cs_n && edge_cnt < BYTE_CLOCKS) begin
			ctl <= {ctl[6:0], din};
		end
	end
	AST_FRAME_LEN: assert property ($rose(cs_n) |-> edge_cnt == FRAME_CLOCKS)
		else $error("frame did not hold 24 serial clocks");
	AST_CS_SETUP: assert property ($fell(cs_n) |-> !serial_shift_clock [*5])
		else $error("serial clock moved too soon after select");
	AST_DIN_LOW_PHASE: assert property ($changed(din) && !cs_n |-> !serial_shift_clock)
		else $error("data input changed while serial clock high");
	AST_BUSY_RISE: assert property ($rose(busy) |-> edge_cnt == BYTE_CLOCKS && !serial_shift_clock)
		else $error("busy rose away from the end of the control byte");
	AST_BUSY_FALL: assert property ($fell(busy) && !cs_n |-> edge_cnt == 5'h09)
		else $error("busy did not last one serial clock");
	AST_TRAIL_LOW: assert property (rise && dout_oe && edge_cnt >= (ctl[RES_BIT] ? 5'h11 : 5'h15) |-> !dout)
		else $error("data output not low in trailing clocks");
	AST_DOUT_LOW_PHASE: assert property ($changed(dout) && dout_oe && $past(dout_oe) |-> !serial_shift_clock)
		else $error("data output changed while serial clock high");
	AST_OE_RELEASE: assert property (cs_n [*5] |-> !dout_oe && !busy_oe)
		else $error("outputs still driven while deselected");
	AST_OE_ENABLE: assert property (!cs_n [*5] |-> dout_oe && busy_oe)
		else $error("outputs not driven while selected");
	AST_INT_MODE11: assert property (!cs_n && edge_cnt >= 5'h09 && ctl[PWR_HI:PWR_LO] == PWR_ALWAYS
		|-> !touch_interrupt_oe)
		else $error("touch interrupt active in always-on mode");
	AST_INT_LEVEL: assert property (touch_interrupt_oe |-> !touch_interrupt_out_n)
		else $error("touch interrupt enabled without pulling low");
	AST_INT_QUIET: assert property (touch_interrupt_oe |-> !busy)
		else $error("touch interrupt enabled while conversion starts");
endmodule : tsc_link_monitor

// ===== testbench.sv
// self-checking bench: both link ends joined, frames ordered over APB
`timescale 1ns/1ps
module testbench;
	import tsc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [31:0] rd;
	logic err;
	logic [11:0] adc = 12'h000;
	logic pen = 1'b0;
	logic clr = 1'b1;
	logic [2:0] mux;
	logic drv, ym, rdiff, refon, adcon, sh, tb0, tb82, bat;
	logic [4:0] seen = 5'h00;
	int err_total = 0;
	int n_tests = 0;
	// ratiometric only on touch channels
	// every address, both resolutions, both reference modes, all power codes
	logic [7:0] frames [8] = '{8'h84, 8'h99, 8'hA6, 8'hB3, 8'hC8, 8'hD2, 8'hEF, 8'hF5};
	always #25 clk = ~clk;
	tsc_link_if link ();
	tsc_host i_tsc_host (.CLK(clk), .RESETN(rst_n), .LINK(link), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
	tsc_device i_tsc_device (.CLK(clk), .RESETN(rst_n), .LINK(link), .ADC_RESULT(adc), .PEN_TOUCH(pen),
		.MUX_SEL(mux), .DRIVERS_ON(drv), .YMINUS_ON(ym), .REF_DIFF(rdiff), .REF_ON(refon), .ADC_ON(adcon),
		.SAMPLE_HOLD(sh), .TEMP_BIAS(tb0), .TEMP_BIAS_X82(tb82), .BAT_DIV_ON(bat));
	tsc_link_monitor i_tsc_link_monitor (.CLK(clk), .RESETN(rst_n), .serial_shift_clock(link.serial_shift_clock),
		.cs_n(link.cs_n), .din(link.din), .dout(link.dout), .dout_oe(link.dout_oe), .busy(link.busy),
		.busy_oe(link.busy_oe), .touch_interrupt_out_n(link.touch_interrupt_out_n),
		.touch_interrupt_oe(link.touch_interrupt_oe));
	// sticky record of analog side effects seen during one frame
	always @(posedge clk) seen <= clr ? 5'h00 : seen | {bat, tb82, tb0, sh, drv};
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task frame(input logic [7:0] cb, input logic [11:0] v);
		logic [2:0] a;
		a = cb[6:4];
		adc <= v;
		clr <= 1'b1;
		apb(1'b1, REG_CTRL, {24'h0, cb});
		clr <= 1'b0;
		// done flag of the previous frame clears only once the new one starts
		repeat (3) @(posedge clk);
		rd = 32'h0;
		for (int k = 0; k < 200 && rd[1] !== 1'b1; k++) apb(1'b0, REG_STATUS, 32'h0);
		chk("status", 32'(rd[1:0]), 32'h2);
		apb(1'b0, REG_RESULT, 32'h0);
		chk("result", rd, cb[RES_BIT] ? {24'h0, v[11:4]} : {20'h0, v});
		apb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl", rd, {24'h0, cb});
		chk("mux", 32'(mux), 32'(a));
		chk("refdiff", 32'(rdiff), 32'(!cb[REFMODE_BIT]));
		chk("refon", 32'(refon), 32'(cb[PWR_HI]));
		chk("adcon", 32'(adcon), 32'(cb[PWR_LO]));
		chk("yminus", 32'(ym), 32'(cb[1:0] == PWR_AUTO));
		chk("sides", 32'(seen), 32'({a == ADDR_BATT, a == ADDR_TEMP1, a == ADDR_TEMP0, 1'b1,
			a inside {3'h1, 3'h3, 3'h4, 3'h5}}));
		$display("frame %h finished", cb);
	endtask : frame
	task report_and_stop;
		$display("comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status idle", rd, 32'h0);
		apb(1'b0, 8'h0C, 32'h0);
		chk("unmapped err", 32'(err), 32'h1);
		chk("unmapped data", rd, 32'h0);
		$display("register test finished");
		// touch held through every frame so the interrupt gating is exercised
		pen <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			frame(frames[i], 12'hA5F - 12'(i * 291));
			if (frames[i][PWR_HI]) begin
				repeat (20) @(posedge clk);
			end
		end
		// last frame left power code 01: touch interrupt enabled
		repeat (20) @(posedge clk);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("touch seen", 32'(rd[2]), 32'h1);
		frame(8'hEF, 12'h3C7);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("touch masked", 32'(rd[2]), 32'h0);
		$display("touch test finished");
		report_and_stop();
	end
	// nine frames of about 300 cycles each plus polling fit well inside
	initial begin
		repeat (40000) @(posedge clk);
		err_total++;
		report_and_stop();
	end
endmodule : testbench
